// *** psc_device.sv ***
// Purpose: sensor end: command decode, conversion model, calibration store
// Assumes: link in mode 0 or 3, one command per chip select frame
// Notes: link logic on the serial clock, conversion on i_ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "psc_params.svh"
module psc_device #(
  parameter int CONV_BASE_CYC = `PSC_CONV_CYC,
  parameter logic [15:0] CAL_ROM [0:7] = '{16'h1234, 16'h71B8, 16'h68BE, 16'h4AB5,
                                           16'h45C9, 16'h7D39, 16'h7A49, 16'h3C4B}
) (
  psc_link_if.dev link,
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [23:0] i_pressure_sample,
  input wire logic [23:0] i_temperature_sample,
  output logic o_busy,
  output logic o_conv_done
);
  // words 0 and 7 of CAL_ROM are arbitrary values

  // link side, frame state
  logic frame_rst;
  logic [4:0] bit_cnt;
  logic [6:0] rx_sr;
  logic [23:0] tx_sr;
  logic cmd_edge;
  logic [7:0] cmd_byte;
  psc_pkg::psc_kind_t kind;
  logic [23:0] resp;

  // link side, persistent state
  logic [15:0] cal_reg [0:7];
  logic cal_loaded;
  logic start_tgl;
  logic conv_type;
  logic [2:0] conv_osr;
  logic cor_tgl;
  logic seen;
  logic fresh;
  logic done_m;
  logic done_s;
  logic busy_m;
  logic busy_s;

  // conversion side
  logic start_m;
  logic start_s;
  logic start_d;
  logic start_e;
  logic cor_m;
  logic cor_s;
  logic cor_d;
  logic cor_e;
  logic [12:0] cnt;
  logic cur_type;
  logic bad;
  logic done_tgl;
  logic [23:0] result;
  logic finish;

  // chip select high holds the frame logic in reset
  assign frame_rst = i_rst | link.cs_n;
  assign cmd_edge = (bit_cnt == 5'h07);
  assign cmd_byte = {rx_sr, link.mosi};
  assign kind = psc_pkg::psc_decode(cmd_byte);
  assign fresh = (done_s != seen);

  // sample on rising edge, valid for modes 0 and 3
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt <= 5'h00;
      rx_sr <= 7'h00;
    end else begin
      rx_sr <= {rx_sr[5:0], link.mosi};
      if (bit_cnt != 5'h1F) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // answer selection at the last command bit
  always_comb begin
    resp = 24'h000000;
    case (kind)
      psc_pkg::KIND_ADC: begin
        if (fresh && !busy_s) begin
          resp = result;
        end
      end
      psc_pkg::KIND_PROM: begin
        resp = {cal_reg[cmd_byte[3:1]], 8'h00};
      end
      default: begin
        resp = 24'h000000;
      end
    endcase
  end

  // answer shift register, msb first
  always_ff @(posedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      tx_sr <= 24'h000000;
    end else if (cmd_edge) begin
      tx_sr <= resp;
    end else if (bit_cnt >= 5'h08) begin
      tx_sr <= {tx_sr[22:0], 1'b0};
    end
  end

  // data out changes on falling edge
  always_ff @(negedge link.sclk or posedge frame_rst) begin
    if (frame_rst) begin
      link.miso <= 1'b0;
      link.miso_oe <= 1'b0;
    end else begin
      link.miso <= tx_sr[23];
      link.miso_oe <= 1'b1;
    end
  end

  // conversion status into the link domain
  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      done_m <= 1'b0;
      done_s <= 1'b0;
      busy_m <= 1'b0;
      busy_s <= 1'b0;
    end else begin
      done_m <= done_tgl;
      done_s <= done_m;
      busy_m <= o_busy;
      busy_s <= busy_m;
    end
  end

  // calibration store loaded by the reset command
  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      cal_loaded <= 1'b0;
      for (int i = 0; i < `PSC_CAL_WORDS; i++) begin
        cal_reg[i] <= 16'h0000;
      end
    end else if (cmd_edge && kind == psc_pkg::KIND_RESET) begin
      cal_loaded <= 1'b1;
      for (int i = 0; i < `PSC_CAL_WORDS; i++) begin
        cal_reg[i] <= CAL_ROM[i];
      end
    end
  end

  // conversion request, held stable for the other domain
  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      start_tgl <= 1'b0;
      conv_type <= 1'b0;
      conv_osr <= 3'h0;
    end else if (cmd_edge && kind == psc_pkg::KIND_CONV) begin
      start_tgl <= ~start_tgl;
      conv_type <= cmd_byte[`PSC_CONV_TYPE_BIT_POS];
      conv_osr <= cmd_byte[3:1];
    end
  end

  // result bookkeeping: a read consumes the result
  always_ff @(posedge link.sclk or posedge i_rst) begin
    if (i_rst) begin
      seen <= 1'b0;
      cor_tgl <= 1'b0;
    end else if (cmd_edge && kind == psc_pkg::KIND_RESET) begin
      seen <= done_s;
    end else if (cmd_edge && kind == psc_pkg::KIND_ADC) begin
      seen <= done_s;
      if (busy_s) begin
        cor_tgl <= ~cor_tgl;
      end
    end
  end

  // request events into the conversion domain
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      start_m <= 1'b0;
      start_s <= 1'b0;
      start_d <= 1'b0;
      cor_m <= 1'b0;
      cor_s <= 1'b0;
      cor_d <= 1'b0;
    end else begin
      start_m <= start_tgl;
      start_s <= start_m;
      start_d <= start_s;
      cor_m <= cor_tgl;
      cor_s <= cor_m;
      cor_d <= cor_s;
    end
  end

  assign start_e = start_s ^ start_d;
  assign cor_e = cor_s ^ cor_d;
  assign finish = o_busy && (cnt == 13'h0001) && !start_e;

  // conversion timer, independent of chip select
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
      cnt <= 13'h0000;
      cur_type <= 1'b0;
    end else if (start_e) begin
      o_busy <= 1'b1;
      cnt <= 13'(CONV_BASE_CYC << conv_osr);
      cur_type <= conv_type;
    end else if (o_busy) begin
      cnt <= cnt - 13'h0001;
      if (cnt == 13'h0001) begin
        o_busy <= 1'b0;
      end
    end
  end

  // restart or read while running spoils the sample
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bad <= 1'b0;
    end else if (start_e) begin
      bad <= o_busy | cor_e;
    end else if (cor_e && o_busy) begin
      bad <= 1'b1;
    end
  end

  // sample capture at end of conversion
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      result <= 24'h000000;
      done_tgl <= 1'b0;
      o_conv_done <= 1'b0;
    end else begin
      o_conv_done <= finish;
      if (finish) begin
        result <= (cur_type ? i_temperature_sample : i_pressure_sample)
                  ^ ((bad | cor_e) ? `PSC_CORRUPT_MASK : 24'h000000);
        done_tgl <= ~done_tgl;
      end
    end
  end
endmodule : psc_device
`default_nettype wire

// *** psc_host.sv ***
// Purpose: host end: command sequencing and integer compensation
// Assumes: one sensor on the link, spi mode 0
// Notes: serial clock is i_ref_clk divided by twice PSC_SCLK_HALF
`timescale 1ns/1ns
`default_nettype none
`include "psc_params.svh"
module psc_host (
  psc_link_if.host link,
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [2:0] i_osr,
  output logic o_busy,
  output logic o_valid,
  output logic signed [31:0] o_temperature,
  output logic signed [31:0] o_pressure
);
  psc_pkg::psc_hstate_t state;
  logic launched;
  logic cal_done;
  logic [2:0] addr;
  logic [2:0] oversampling_ratio;
  logic [12:0] wcnt;
  logic xf_go;
  logic xf_busy;
  logic xf_done;
  logic [31:0] xf_word;
  logic [5:0] xf_bits;
  logic [5:0] bits_left;
  logic [2:0] div;
  logic [31:0] tx_sr;
  logic [23:0] rx_sr;
  logic miso_m;
  logic miso_s;
  logic [15:0] coeff [1:6];
  logic [23:0] d1;
  logic [23:0] d2;
  logic signed [63:0] dt;
  logic signed [63:0] temp;
  logic signed [63:0] off;
  logic signed [63:0] sensitivity_at_temperature;
  logic signed [63:0] pres;

  assign link.mosi = tx_sr[31];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_m <= link.miso & link.miso_oe;
      miso_s <= miso_m;
    end
  end

  // command word for the current state
  always_comb begin
    xf_word = 32'h00000000;
    xf_bits = `PSC_BITS_CMD;
    case (state)
      psc_pkg::HS_RESET: xf_word[31:24] = `PSC_CMD_RESET;
      psc_pkg::HS_PROM: begin
        xf_word[31:24] = `PSC_CMD_PROM_BASE | {4'h0, addr, 1'b0};
        xf_bits = `PSC_BITS_PROM;
      end
      psc_pkg::HS_CONV_P: xf_word[31:24] = `PSC_CMD_CONV_BASE | {4'h0, oversampling_ratio, 1'b0};
      psc_pkg::HS_CONV_T: xf_word[31:24] = `PSC_CMD_CONV_BASE | {4'h1, oversampling_ratio, 1'b0};
      psc_pkg::HS_READ_P, psc_pkg::HS_READ_T: begin
        xf_word[31:24] = `PSC_CMD_ADC_READ;
        xf_bits = `PSC_BITS_ADC;
      end
      default: xf_bits = `PSC_BITS_CMD;
    endcase
  end

  assign xf_go = !launched && !xf_busy && (state != psc_pkg::HS_IDLE) && (state != psc_pkg::HS_CALC)
                 && (state != psc_pkg::HS_WAIT_P) && (state != psc_pkg::HS_WAIT_T);

  // serial engine: one frame per command, mode 0
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      xf_busy <= 1'b0;
      xf_done <= 1'b0;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      div <= 3'h0;
      bits_left <= 6'h00;
      tx_sr <= 32'h00000000;
      rx_sr <= 24'h000000;
    end else begin
      xf_done <= 1'b0;
      if (xf_go) begin
        xf_busy <= 1'b1;
        link.cs_n <= 1'b0;
        div <= 3'h0;
        bits_left <= xf_bits;
        tx_sr <= xf_word;
      end else if (xf_busy) begin
        if (div == `PSC_SCLK_HALF - 3'h1) begin
          div <= 3'h0;
          if (bits_left == 6'h00) begin
            link.cs_n <= 1'b1;
            xf_busy <= 1'b0;
            xf_done <= 1'b1;
          end else if (!link.sclk) begin
            link.sclk <= 1'b1;
            rx_sr <= {rx_sr[22:0], miso_s};
          end else begin
            link.sclk <= 1'b0;
            tx_sr <= {tx_sr[30:0], 1'b0};
            bits_left <= bits_left - 6'h01;
          end
        end else begin
          div <= div + 3'h1;
        end
      end
    end
  end

  // sequencer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= psc_pkg::HS_IDLE;
      launched <= 1'b0;
      cal_done <= 1'b0;
      addr <= `PSC_COEFF_FIRST;
      oversampling_ratio <= 3'h0;
      wcnt <= 13'h0000;
      o_busy <= 1'b0;
    end else begin
      if (xf_go) begin
        launched <= 1'b1;
      end else if (xf_done) begin
        launched <= 1'b0;
      end
      case (state)
        psc_pkg::HS_IDLE: begin
          o_busy <= 1'b0;
          if (i_start) begin
            o_busy <= 1'b1;
            oversampling_ratio <= (i_osr > `PSC_OSR_MAX) ? `PSC_OSR_MAX : i_osr;
            state <= cal_done ? psc_pkg::HS_CONV_P : psc_pkg::HS_RESET;
          end
        end
        psc_pkg::HS_RESET: if (xf_done) state <= psc_pkg::HS_PROM;
        psc_pkg::HS_PROM: begin
          if (xf_done) begin
            if (addr == `PSC_COEFF_LAST) begin
              cal_done <= 1'b1;
              state <= psc_pkg::HS_CONV_P;
            end else begin
              addr <= addr + 3'h1;
            end
          end
        end
        psc_pkg::HS_CONV_P, psc_pkg::HS_CONV_T: begin
          if (xf_done) begin
            wcnt <= 13'(`PSC_CONV_CYC << oversampling_ratio) + `PSC_WAIT_MARGIN;
            state <= (state == psc_pkg::HS_CONV_P) ? psc_pkg::HS_WAIT_P : psc_pkg::HS_WAIT_T;
          end
        end
        psc_pkg::HS_WAIT_P, psc_pkg::HS_WAIT_T: begin
          wcnt <= wcnt - 13'h0001;
          if (wcnt == 13'h0000) begin
            state <= (state == psc_pkg::HS_WAIT_P) ? psc_pkg::HS_READ_P : psc_pkg::HS_READ_T;
          end
        end
        psc_pkg::HS_READ_P: if (xf_done) state <= psc_pkg::HS_CONV_T;
        psc_pkg::HS_READ_T: if (xf_done) state <= psc_pkg::HS_CALC;
        default: state <= psc_pkg::HS_IDLE;
      endcase
    end
  end

  // captured words
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      d1 <= 24'h000000;
      d2 <= 24'h000000;
      for (int i = 1; i <= 6; i++) begin
        coeff[i] <= 16'h0000;
      end
    end else if (xf_done) begin
      if (state == psc_pkg::HS_PROM) coeff[addr] <= rx_sr[15:0];
      if (state == psc_pkg::HS_READ_P) d1 <= rx_sr;
      if (state == psc_pkg::HS_READ_T) d2 <= rx_sr;
    end
  end

  // compensation arithmetic, 64-bit signed
  always_comb begin
    dt = $signed({40'h0, d2}) - ($signed({48'h0, coeff[5]}) <<< `PSC_SH_TREF);
    temp = `PSC_TEMP_BASE + ((dt * $signed({48'h0, coeff[6]})) >>> `PSC_SH_TEMP);
    off = ($signed({48'h0, coeff[2]}) <<< `PSC_SH_OFF)
          + (($signed({48'h0, coeff[4]}) * dt) >>> `PSC_SH_OFF_T);
    sensitivity_at_temperature = ($signed({48'h0, coeff[1]}) <<< `PSC_SH_SENSITIVITY_AT_TEMPERATURE)
           + (($signed({48'h0, coeff[3]}) * dt) >>> `PSC_SH_SENSITIVITY_AT_TEMPERATURE_T);
    pres = ((($signed({40'h0, d1}) * sensitivity_at_temperature) >>> `PSC_SH_P1) - off) >>> `PSC_SH_P2;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_valid <= 1'b0;
      o_temperature <= 32'sh00000000;
      o_pressure <= 32'sh00000000;
    end else begin
      o_valid <= (state == psc_pkg::HS_CALC);
      if (state == psc_pkg::HS_CALC) begin
        o_temperature <= temp[31:0];
        o_pressure <= pres[31:0];
      end
    end
  end
endmodule : psc_host
`default_nettype wire

// *** psc_link_if.sv ***
// Purpose: serial link between host and sensor
// Assumes: host drives clock, select and data in
// Notes: miso is only meaningful while miso_oe is high
`timescale 1ns/1ns
`default_nettype none
interface psc_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso, input miso_oe);
endinterface : psc_link_if
`default_nettype wire

// *** psc_link_properties.sv ***
// Purpose: checks on the link between host and sensor ends
// Assumes: host clocks the link from i_ref_clk, spi mode 0
// Notes: helper counters track bits, command bytes and frames
`timescale 1ns/1ns
`default_nettype none
`include "psc_params.svh"
module psc_link_properties (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic sclk_q;
  logic cs_q;
  logic last_conv;
  logic [5:0] rises;
  logic [7:0] cmd;
  logic [3:0] frame_idx;
  logic [12:0] idle_cnt;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_q <= 1'b0;
      cs_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q <= cs_n;
    end
  end
  // serial clock rises and command bits within a frame
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rises <= 6'h00;
      cmd <= 8'h00;
    end else if (cs_n) begin
      rises <= 6'h00;
    end else if (sclk && !sclk_q) begin
      rises <= rises + 6'h01;
      if (rises < 6'h08) begin
        cmd <= {cmd[6:0], mosi};
      end
    end
  end
  // frame count and kind of the last frame
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      frame_idx <= 4'h0;
      last_conv <= 1'b0;
    end else if (cs_n && !cs_q) begin
      frame_idx <= frame_idx + {3'h0, frame_idx != 4'hF};
      last_conv <= rises == 6'h08 && (cmd & `PSC_CMD_CONV_MASK) == `PSC_CMD_CONV_BASE;
    end
  end
  // cycles spent with chip select high
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_cnt <= 13'h0000;
    end else if (!cs_n) begin
      idle_cnt <= 13'h0000;
    end else if (idle_cnt != 13'h1FFF) begin
      idle_cnt <= idle_cnt + 13'h0001;
    end
  end
  property p_no_drive_idle;
    cs_n |-> !miso_oe && !miso;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) else $error("miso driven while deselected");
  property p_idle_low;
    cs_n |-> !sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("serial clock not idle low");
  property p_setup;
    $fell(cs_n) |-> !sclk [*3];
  endproperty
  a_setup: assert property (p_setup) else $error("clock rose too soon after select");
  property p_high_phase;
    $rose(sclk) |-> sclk [*4] ##1 !sclk;
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("serial clock high phase wrong");
  property p_mosi_hold;
    $rose(sclk) |-> $stable(mosi) [*4];
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while clock high");
  property p_frame_len;
    $rose(cs_n) |-> rises == 6'h08 || rises == 6'h18 || rises == 6'h20;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_quiet_cmd;
    !cs_n && rises < 6'h08 |-> !miso;
  endproperty
  a_quiet_cmd: assert property (p_quiet_cmd) else $error("miso active during command byte");
  property p_first_reset;
    !cs_n && rises == 6'h08 && frame_idx == 4'h0 |-> cmd == `PSC_CMD_RESET;
  endproperty
  a_first_reset: assert property (p_first_reset) else $error("first frame is not reset");
  property p_prom_order;
    !cs_n && rises == 6'h08 && frame_idx >= 4'h1 && frame_idx <= 4'h6 |-> cmd == {4'hA, frame_idx[2:0], 1'b0};
  endproperty
  a_prom_order: assert property (p_prom_order) else $error("calibration reads out of order");
  property p_conv_gap;
    $fell(cs_n) && last_conv |-> idle_cnt >= `PSC_CONV_CYC;
  endproperty
  a_conv_gap: assert property (p_conv_gap) else $error("frame during conversion");
  c_prom: cover property ($rose(cs_n) && rises == 6'h18);
  c_adc: cover property ($rose(cs_n) && rises == 6'h20);
  c_conv: cover property ($fell(cs_n) && last_conv);
endmodule : psc_link_properties
`default_nettype wire

// *** psc_params.svh ***
// Purpose: constants for the pressure sensor command link
// Assumes: 25 MHz reference clock at both ends
// Notes: shared by the package and both ends
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_CMD_RESET 8'h1E
`define PSC_CMD_ADC_READ 8'h00
`define PSC_CMD_CONV_BASE 8'h40
`define PSC_CMD_CONV_MASK 8'hE1
`define PSC_CMD_PROM_BASE 8'hA0
`define PSC_CMD_PROM_MASK 8'hF1
`define PSC_CONV_TYPE_BIT_POS 4
`define PSC_OSR_MAX 3'h4
`define PSC_CAL_WORDS 8
`define PSC_COEFF_FIRST 3'h1
`define PSC_COEFF_LAST 3'h6
`define PSC_BITS_CMD 6'h08
`define PSC_BITS_PROM 6'h18
`define PSC_BITS_ADC 6'h20
`define PSC_REF_CLK_MHZ 25
`define PSC_CONV_TIME_US 10
`define PSC_CONV_CYC (`PSC_CONV_TIME_US * `PSC_REF_CLK_MHZ)
`define PSC_WAIT_MARGIN 13'h010
`define PSC_SCLK_HALF 3'h4
`define PSC_CORRUPT_MASK 24'h5A5A5A
`define PSC_TEMP_BASE 64'sh00000000000007D0
`define PSC_SH_TREF 8
`define PSC_SH_TEMP 23
`define PSC_SH_OFF 16
`define PSC_SH_OFF_T 7
`define PSC_SH_SENSITIVITY_AT_TEMPERATURE 15
`define PSC_SH_SENSITIVITY_AT_TEMPERATURE_T 8
`define PSC_SH_P1 21
`define PSC_SH_P2 13
`endif

// *** psc_pkg.sv ***
// Purpose: types and command decode for the sensor link
// Assumes: psc_params.svh
// Notes: no state of its own
`default_nettype none
`include "psc_params.svh"
package psc_pkg;
  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_RESET = 3'h1,
    KIND_CONV = 3'h2,
    KIND_ADC = 3'h3,
    KIND_PROM = 3'h4
  } psc_kind_t;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h0,
    HS_RESET = 4'h1,
    HS_PROM = 4'h3,
    HS_CONV_P = 4'h2,
    HS_WAIT_P = 4'h6,
    HS_READ_P = 4'h7,
    HS_CONV_T = 4'h5,
    HS_WAIT_T = 4'h4,
    HS_READ_T = 4'hC,
    HS_CALC = 4'hD
  } psc_hstate_t;

  function automatic psc_kind_t psc_decode(input logic [7:0] c);
    psc_kind_t k;
    k = KIND_NONE;
    if (c == `PSC_CMD_RESET) begin
      k = KIND_RESET;
    end else if (c == `PSC_CMD_ADC_READ) begin
      k = KIND_ADC;
    end else if ((c & `PSC_CMD_CONV_MASK) == `PSC_CMD_CONV_BASE && c[3:1] <= `PSC_OSR_MAX) begin
      k = KIND_CONV;
    end else if ((c & `PSC_CMD_PROM_MASK) == `PSC_CMD_PROM_BASE) begin
      k = KIND_PROM;
    end
    return k;
  endfunction : psc_decode
endpackage : psc_pkg
`default_nettype wire

// *** tb.sv ***
// Purpose: testbench for host and sensor ends of the link
// Assumes: second sensor end driven by the bench as a rule-breaking host
// Notes: bench serial clock 64 ns, runs within frames and, in the noise task, while deselected
`timescale 1ns/1ns
`default_nettype none
`include "psc_params.svh"
module tb;
  localparam logic [15:0] CAL [0:7] = '{16'h0A5C, 16'h71B8, 16'h68BE, 16'h4AB5,
                                        16'h45C9, 16'h7D39, 16'h7A49, 16'hC3D7};
  localparam logic [23:0] P2 = 24'hC3A51E;
  localparam logic [23:0] T2 = 24'h3C5AE1;
  logic i_ref_clk;
  logic i_rst;
  logic i_start;
  logic [2:0] i_osr;
  logic [23:0] d1;
  logic [23:0] d2;
  logic d_busy;
  logic d_done;
  logic b_busy;
  logic b_done;
  logic h_busy;
  logic h_valid;
  logic signed [31:0] h_temp;
  logic signed [31:0] h_pres;
  int n_mismatch;
  int checks_done;
  int busy_cnt;
  int done_cnt;
  psc_link_if lk ();
  psc_link_if lk2 ();
  psc_host psc_host_inst (.link(lk.host), .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_start(i_start), .i_osr(i_osr),
    .o_busy(h_busy), .o_valid(h_valid), .o_temperature(h_temp), .o_pressure(h_pres));
  psc_device #(.CONV_BASE_CYC(`PSC_CONV_CYC), .CAL_ROM(CAL)) psc_device_inst (.link(lk.dev), .i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_pressure_sample(d1), .i_temperature_sample(d2), .o_busy(d_busy), .o_conv_done(d_done));
  psc_device #(.CONV_BASE_CYC(`PSC_CONV_CYC), .CAL_ROM(CAL)) psc_device_inst_b (.link(lk2.dev), .i_ref_clk(i_ref_clk),
    .i_rst(i_rst), .i_pressure_sample(P2), .i_temperature_sample(T2), .o_busy(b_busy), .o_conv_done(b_done));
  psc_link_properties psc_link_properties_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .sclk(lk.sclk), .cs_n(lk.cs_n),
    .mosi(lk.mosi), .miso(lk.miso), .miso_oe(lk.miso_oe));
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(negedge i_ref_clk) begin
    if (b_busy === 1'b1) begin
      busy_cnt++;
    end
    if (d_done === 1'b1) begin
      done_cnt++;
    end
  end
  task automatic end_sim();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_flag(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flag
  // one frame as link master; undriven answer bits read as unknown
  task automatic xfer(input logic [7:0] c, input int nb, input bit m3, output logic [31:0] rx);
    logic [31:0] tx;
    tx = {c, 24'h000000};
    rx = 32'h00000000;
    lk2.sclk = m3;
    #16 lk2.cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      if (m3) begin
        #32 lk2.sclk = 1'b0;
      end
      lk2.mosi = tx[31];
      tx = tx << 1;
      #32 lk2.sclk = 1'b1;
      rx = {rx[30:0], lk2.miso_oe ? lk2.miso : 1'bx};
      if (!m3) begin
        #32 lk2.sclk = 1'b0;
      end
    end
    #32 lk2.cs_n = 1'b1;
    lk2.mosi = ~lk2.mosi;
    #16 lk2.sclk = 1'b0;
    #40;
  endtask : xfer
  task automatic rd(input logic [7:0] c, input int nb, input bit m3, input logic [31:0] exp);
    logic [31:0] r;
    xfer(c, nb, m3, r);
    chk_word(r & ((32'h00000001 << (nb - 8)) - 32'h00000001), exp);
  endtask : rd
  // traffic for another device while deselected
  task automatic noise();
    repeat (8) begin
      lk2.mosi = ~lk2.mosi;
      #32 lk2.sclk = 1'b1;
      #32 lk2.sclk = 1'b0;
    end
  endtask : noise
  task automatic conv(input logic [7:0] c, input int mode, input logic [31:0] exp);
    logic [31:0] r;
    int k;
    busy_cnt = 0;
    xfer(c, 8, c[1], r);
    k = 0;
    while (b_busy !== 1'b1 && k < 20) begin
      @(negedge i_ref_clk);
      k++;
    end
    if (mode == 1) begin
      noise();
    end
    if (mode == 2) begin
      rd(8'h00, 32, 1'b0, 32'h00000000);
    end
    k = 0;
    while (b_busy === 1'b1 && k < 5000) begin
      @(negedge i_ref_clk);
      k++;
    end
    chk_flag(b_done, 1'b1);
    chk_word(32'(busy_cnt), 32'(`PSC_CONV_CYC) << c[3:1]);
    rd(8'h00, 32, c[2], exp);
  endtask : conv
  task automatic dev_tests();
    logic [31:0] r;
    logic [7:0] c;
    rd(8'hA2, 24, 1'b0, 32'h00000000);
    xfer(8'h1E, 8, 1'b0, r);
    for (int a = 0; a < 8; a++) begin
      rd(8'hA0 | 8'(a << 1), 24, a[0], {16'h0000, CAL[a]});
    end
    rd(8'h00, 32, 1'b0, 32'h00000000);
    xfer(8'h4A, 8, 1'b0, r);
    repeat (10) @(negedge i_ref_clk);
    chk_flag(b_busy, 1'b0);
    for (int k = 0; k < 10; k++) begin
      c = (k < 5 ? 8'h40 : 8'h50) | 8'((k % 5) << 1);
      conv(c, k == 0 ? 1 : 0, {8'h00, c[4] ? T2 : P2});
    end
    rd(8'h00, 32, 1'b1, 32'h00000000);
    xfer(8'h50, 8, 1'b0, r);
    repeat (300) @(negedge i_ref_clk);
    conv(8'h40, 2, {8'h00, P2 ^ `PSC_CORRUPT_MASK});
    xfer(8'h50, 8, 1'b0, r);
    repeat (300) @(negedge i_ref_clk);
    xfer(8'h1E, 8, 1'b0, r);
    rd(8'h00, 32, 1'b0, 32'h00000000);
  endtask : dev_tests
  task automatic hmeas(input logic [2:0] oversampling_ratio, input logic [23:0] p, input logic [23:0] t);
    longint dt;
    longint te;
    longint off;
    longint sensitivity_at_temperature;
    longint pe;
    int k;
    d1 = p;
    d2 = t;
    i_osr = oversampling_ratio;
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    repeat (20) @(negedge i_ref_clk);
    i_start = 1'b1;
    @(negedge i_ref_clk);
    i_start = 1'b0;
    k = 0;
    while (h_valid !== 1'b1 && k < 20000) begin
      @(negedge i_ref_clk);
      k++;
    end
    chk_flag(h_valid, 1'b1);
    chk_flag(d_busy, 1'b0);
    dt = longint'(t) - (longint'(CAL[5]) <<< 8);
    te = 2000 + ((dt * longint'(CAL[6])) >>> 23);
    off = (longint'(CAL[2]) <<< 16) + ((longint'(CAL[4]) * dt) >>> 7);
    sensitivity_at_temperature = (longint'(CAL[1]) <<< 15) + ((longint'(CAL[3]) * dt) >>> 8);
    pe = (((longint'(p) * sensitivity_at_temperature) >>> 21) - off) >>> 13;
    chk_word(h_temp, te[31:0]);
    chk_word(h_pres, pe[31:0]);
    repeat (40) @(negedge i_ref_clk);
    chk_flag(h_busy, 1'b0);
  endtask : hmeas
  initial begin
    #2000000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    n_mismatch = 0;
    checks_done = 0;
    busy_cnt = 0;
    done_cnt = 0;
    i_rst = 1'b1;
    i_start = 1'b0;
    i_osr = 3'h0;
    d1 = 24'h000000;
    d2 = 24'h000000;
    lk2.sclk = 1'b0;
    lk2.cs_n = 1'b1;
    lk2.mosi = 1'b0;
    repeat (5) @(negedge i_ref_clk);
    i_rst = 1'b0;
    fork
      begin
        hmeas(3'h0, 24'h4B71EC, 24'h7D1B3E);
        hmeas(3'h5, 24'h6A2B1C, 24'h7E0F00);
        chk_word(32'(done_cnt), 32'h00000004);
      end
      dev_tests();
    join
    end_sim();
  end
endmodule : tb
`default_nettype wire
